// >>> rtl/gpdio_pkg.sv
// constants shared by the pin data register block
package gpdio_pkg;
   localparam int GPDIO_PINS = 16;
   localparam int GPDIO_AW = 12;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] GPDIO_UPPER_IN_OFS = 12'h640;
   localparam logic [11:0] GPDIO_LOWER_OUT_OFS = 12'h644;
   // ----------------------------------------------------------------
   // reset values and field layout
   // ----------------------------------------------------------------
   localparam logic [15:0] GPDIO_UPPER_IN_RST = 16'hAAAA;
   localparam logic [15:0] GPDIO_LOWER_OUT_RST = 16'h0000;
   localparam logic [15:0] GPDIO_RSVD_HI = 16'h0000;
   localparam logic [31:0] GPDIO_UNMAPPED = 32'h0000_0000;
   localparam logic GPDIO_DIR_OUT = 1'b1;
   localparam int GPDIO_DIR_BIT = 1;
   localparam int GPDIO_SYNC_STAGES = 3;
endpackage

// >>> rtl/gpdio_sync_if.sv
// carrier for synchronised pin levels between the block's modules
`timescale 1ns/100ps
`default_nettype none
interface gpdio_sync_if #(parameter int W = 16);
   logic [W-1:0] level;
   modport src (output level);
   modport dst (input level);
endinterface
`default_nettype wire

// >>> rtl/gpdio_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module gpdio_pin_sync #(
   parameter int W = 16,
   parameter logic [15:0] RST_LEVEL = gpdio_pkg::GPDIO_UPPER_IN_RST
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] pin_in,
   gpdio_sync_if.src sync
);
   import gpdio_pkg::*;
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   if (W < 1 || W > 16) begin : g_bad_w
      $error("gpdio_pin_sync: W must be 1..16");
   end

   // ----------------------------------------------------------------
   // synchroniser chain
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= RST_LEVEL[W-1:0];
         stage2 <= RST_LEVEL[W-1:0];
         stage3 <= RST_LEVEL[W-1:0];
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // per bit: accept once second and third stage agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync.level <= RST_LEVEL[W-1:0];
      end else begin
         sync.level <= (stage3 & ~(stage2 ^ stage3)) | (sync.level & (stage2 ^ stage3));
      end
   end

   a_level_from_pin: assert property (@(posedge clk) disable iff (rst)
      ((sync.level ^ $past(sync.level)) & (sync.level ^ $past(pin_in, 4))) == '0)
      else $error("accepted level does not match pin four cycles back");
endmodule // gpdio_pin_sync
`default_nettype wire

// >>> rtl/gpdio_data_regs.sv
// pin data registers: upper-pin input levels, lower-pin output levels
`timescale 1ns/100ps
`default_nettype none
module gpdio_data_regs #(
   parameter int PINS = gpdio_pkg::GPDIO_PINS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [gpdio_pkg::GPDIO_AW-1:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic [31:0] lower_dir,
   input wire logic [31:0] upper_dir,
   input wire logic [PINS-1:0] upper_pin_in,
   output logic [PINS-1:0] lower_pin_out,
   output logic [PINS-1:0] lower_pin_oe
);
   import gpdio_pkg::*;

   if (PINS != GPDIO_PINS) begin : g_bad_pins
      $error("gpdio_data_regs: PINS must be 16");
   end

   // ----------------------------------------------------------------
   // direction decode
   // ----------------------------------------------------------------
   // picks bit 2n+1 of a direction word for each pin n
   function automatic logic [15:0] dir_is_out(input logic [31:0] dir);
      logic [15:0] res;
      res = '0;
      for (int n = 0; n < 16; n++) begin
         res[n] = (dir[2*n+GPDIO_DIR_BIT] == GPDIO_DIR_OUT);
      end
      return res;
   endfunction

   logic [15:0] upper_out_mask;
   logic [15:0] lower_out_mask;
   assign upper_out_mask = dir_is_out(upper_dir);
   assign lower_out_mask = dir_is_out(lower_dir);

   // ----------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------
   // pins are asynchronous to clk: a level counts once two stages agree
   gpdio_sync_if #(.W(PINS)) upper_sync ();

   gpdio_pin_sync #(
      .W(PINS),
      .RST_LEVEL(GPDIO_UPPER_IN_RST)
   ) u_upper_sync (
      .clk(clk),
      .rst(rst),
      .pin_in(upper_pin_in),
      .sync(upper_sync)
   );

   // output pins read zero whatever the board puts on them
   logic [15:0] upper_in_view;
   assign upper_in_view = upper_sync.level & ~upper_out_mask;

   // ----------------------------------------------------------------
   // lower output data register and pin drive
   // ----------------------------------------------------------------
   logic wr_lower_out;
   assign wr_lower_out = cfg_wr && (cfg_addr == GPDIO_LOWER_OUT_OFS);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lower_pin_out <= GPDIO_LOWER_OUT_RST;
      end else if (wr_lower_out) begin
         lower_pin_out <= cfg_wdata[15:0];
      end
   end

   // drive enable lags the direction word by one clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lower_pin_oe <= '0;
      end else begin
         lower_pin_oe <= lower_out_mask;
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   // a read and a write in one cycle return the old value
   logic [31:0] next_rdata;
   always_comb begin
      unique case (cfg_addr)
         GPDIO_UPPER_IN_OFS: next_rdata = {GPDIO_RSVD_HI, upper_in_view};
         GPDIO_LOWER_OUT_OFS: next_rdata = {GPDIO_RSVD_HI, lower_pin_out};
         default: next_rdata = GPDIO_UNMAPPED;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_rdata <= GPDIO_UNMAPPED;
      end else if (cfg_rd) begin
         cfg_rdata <= next_rdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_rd;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // each check but a_write_drives looks one clock after the request that it guards; a_write_drives looks two clocks after
   a_out_pin_zero: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && cfg_addr == GPDIO_UPPER_IN_OFS
      |=> (cfg_rdata[15:0] & $past(upper_out_mask)) == 16'h0000)
      else $error("upper input bit not zero for an output pin");

   a_in_pin_level: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && cfg_addr == GPDIO_UPPER_IN_OFS && upper_dir == 32'h0000_0000
      |=> cfg_rdata[15:0] == $past(upper_sync.level))
      else $error("upper input bit does not show the pin level");

   a_dir_odd_bit: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && cfg_addr == GPDIO_UPPER_IN_OFS && upper_dir == 32'h5555_5555
      |=> cfg_rdata[15:0] == $past(upper_sync.level))
      else $error("even direction bit wrongly treated as direction");

   a_write_drives: assert property (@(posedge clk) disable iff (rst)
      wr_lower_out ##1 !wr_lower_out[*2]
      |-> lower_pin_out == $past(cfg_wdata[15:0], 2))
      else $error("written output value not held on the pins");

   a_oe_follows_dir: assert property (@(posedge clk) disable iff (rst)
      lower_dir == 32'hAAAA_AAAA ##1 lower_dir == 32'hAAAA_AAAA
      |-> lower_pin_oe == 16'hFFFF)
      else $error("pin not driven though direction selects output");

   a_rsvd_read_zero: assert property (@(posedge clk) disable iff (rst)
      cfg_rd |=> cfg_rvalid && cfg_rdata[31:16] == 16'h0000)
      else $error("reserved upper bits read non-zero");

   a_out_stored: assert property (@(posedge clk) disable iff (rst)
      wr_lower_out |=> lower_pin_out == $past(cfg_wdata[15:0]))
      else $error("written output value not stored");

   a_out_kept: assert property (@(posedge clk) disable iff (rst)
      !wr_lower_out |=> $stable(lower_pin_out))
      else $error("output value changed without a write to it");

   a_ro_write_ignored: assert property (@(posedge clk) disable iff (rst)
      cfg_wr && cfg_addr == GPDIO_UPPER_IN_OFS |=> $stable(lower_pin_out))
      else $error("write to the read-only register had an effect");

   a_lower_readback: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && cfg_addr == GPDIO_LOWER_OUT_OFS
      |=> cfg_rdata == {16'h0000, $past(lower_pin_out)})
      else $error("output register does not read back its value");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && cfg_addr != GPDIO_UPPER_IN_OFS && cfg_addr != GPDIO_LOWER_OUT_OFS
      |=> cfg_rdata == 32'h0000_0000)
      else $error("unmapped offset did not read zero");

   a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
      !cfg_rd |=> !cfg_rvalid)
      else $error("read valid without a read");

   a_rdata_held: assert property (@(posedge clk) disable iff (rst)
      !cfg_rd |=> $stable(cfg_rdata))
      else $error("read data changed without a read");

   a_upper_all_out: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && cfg_addr == GPDIO_UPPER_IN_OFS && upper_dir == 32'hAAAA_AAAA
      |=> cfg_rdata == 32'h0000_0000)
      else $error("all-output upper pins did not read zero");

   a_dir_even_ignored: assert property (@(posedge clk) disable iff (rst)
      lower_dir == 32'h5555_5555 |=> lower_pin_oe == 16'h0000)
      else $error("even direction bit wrongly enabled a pin");

   // ----------------------------------------------------------------
   // per-pin checks against the direction words and the written data
   // ----------------------------------------------------------------
   for (genvar n = 0; n < PINS; n++) begin : g_pin_chk
      a_upper_out_zero: assert property (@(posedge clk) disable iff (rst)
         cfg_rd && cfg_addr == GPDIO_UPPER_IN_OFS && upper_dir[2*n+GPDIO_DIR_BIT]
         |=> cfg_rdata[n] == 1'b0)
         else $error("upper output pin does not read zero");

      a_upper_in_level: assert property (@(posedge clk) disable iff (rst)
         cfg_rd && cfg_addr == GPDIO_UPPER_IN_OFS && !upper_dir[2*n+GPDIO_DIR_BIT]
         |=> cfg_rdata[n] == $past(upper_sync.level[n]))
         else $error("upper input pin does not read its level");

      a_oe_pin_dir: assert property (@(posedge clk) disable iff (rst)
         !$past(rst) |-> lower_pin_oe[n] == $past(lower_dir[2*n+GPDIO_DIR_BIT]))
         else $error("pin drive does not follow its direction bit");

      a_pin_bit_stored: assert property (@(posedge clk) disable iff (rst)
         wr_lower_out |=> lower_pin_out[n] == $past(cfg_wdata[n]))
         else $error("written bit not stored for its pin");
   end
endmodule // gpdio_data_regs
`default_nettype wire

// >>> sim/gpdio_board.sv
// board-side model of the port's pins
`timescale 1ns/100ps
`default_nettype none
module gpdio_board (
   input wire logic [15:0] level_cmd,
   input wire logic [15:0] drv_val,
   input wire logic [15:0] drv_en,
   output logic [15:0] upper_pin_in,
   output logic [15:0] lower_wire
);
   // undriven lower pins fall to the board pull-down
   assign lower_wire = drv_val & drv_en;
   assign upper_pin_in = level_cmd;
endmodule // gpdio_board
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the pin data registers
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import gpdio_pkg::*;
   logic clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, cfg_rvalid;
   logic [11:0] cfg_addr = 12'h000;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata, lower_dir = 32'h0, upper_dir = 32'h0, w;
   logic [15:0] lvl = 16'h0, upper_pin_in, lower_pin_out, lower_pin_oe, lower_wire;
   logic [15:0] lfsr = 16'hD375;
   int mismatches = 0, num_checks = 0;

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   function automatic logic [15:0] odd(input logic [31:0] d);
      for (int i = 0; i < 16; i++)
         odd[i] = d[2*i+1];
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one register access, answer sampled half a cycle after it is taken
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      cfg_wr <= wr;
      cfg_rd <= ~wr;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b0;
      @(negedge clk);
      if (!wr)
         chk("rvalid", 32'h1, {31'h0, cfg_rvalid});
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      forever #4 clk = ~clk;
   end

   initial begin
      #100000;
      mismatches++;
      finish_test();
   end

   gpdio_board i_board (.level_cmd(lvl), .drv_val(lower_pin_out), .drv_en(lower_pin_oe),
      .upper_pin_in(upper_pin_in), .lower_wire(lower_wire));

   gpdio_data_regs i_dut (.clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .lower_dir(lower_dir), .upper_dir(upper_dir), .upper_pin_in(upper_pin_in),
      .lower_pin_out(lower_pin_out), .lower_pin_oe(lower_pin_oe));

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("out_rst", 32'h0, {16'h0, lower_pin_out});
      chk("oe_rst", 32'h0, {16'h0, lower_pin_oe});
      for (int k = 0; k < 40; k++) begin
         w = (k == 0) ? 32'hFFFF_FFFF : {rnd(), rnd()};
         @(posedge clk);
         lvl <= (k == 1) ? 16'hFFFF : rnd();
         lower_dir <= (k == 1) ? 32'hAAAA_AAAA : (k == 2) ? 32'h5555_5555 : {rnd(), rnd()};
         upper_dir <= (k == 1) ? 32'hAAAA_AAAA : (k == 2) ? 32'h5555_5555 : {rnd(), rnd()};
         acc(1'b1, GPDIO_LOWER_OUT_OFS, w);
         chk("pin_out", {16'h0, w[15:0]}, {16'h0, lower_pin_out});
         chk("pin_oe", {16'h0, odd(lower_dir)}, {16'h0, lower_pin_oe});
         chk("wire", {16'h0, w[15:0] & odd(lower_dir)}, {16'h0, lower_wire});
         // read-only register must ignore this write
         acc(1'b1, GPDIO_UPPER_IN_OFS, ~w);
         repeat (4) @(posedge clk);
         acc(1'b0, GPDIO_UPPER_IN_OFS, 32'h0);
         chk("upper_in", {16'h0, lvl & ~odd(upper_dir)}, cfg_rdata);
         acc(1'b0, GPDIO_LOWER_OUT_OFS, 32'h0);
         chk("lower_rd", {16'h0, w[15:0]}, cfg_rdata);
         acc(1'b0, 12'h648, 32'h0);
         chk("unmapped", GPDIO_UNMAPPED, cfg_rdata);
      end
      // mid-run reset: defaults return, upper levels show their reset pattern
      @(posedge clk);
      rst <= 1'b1;
      lower_dir <= 32'h0000_0000;
      upper_dir <= 32'h0000_0000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("out_rst2", 32'h0, {16'h0, lower_pin_out});
      chk("oe_rst2", 32'h0, {16'h0, lower_pin_oe});
      acc(1'b0, GPDIO_UPPER_IN_OFS, 32'h0);
      chk("upper_rst", {16'h0, GPDIO_UPPER_IN_RST}, cfg_rdata);
      acc(1'b0, GPDIO_LOWER_OUT_OFS, 32'h0);
      chk("lower_rst", {16'h0, GPDIO_LOWER_OUT_RST}, cfg_rdata);
      finish_test();
   end
endmodule // testbench
`default_nettype wire
